// File: core/dac_top.sv
// Purpose: digital side of a dual simultaneous-sampling converter
// Assumes: samples arrive from the analog core as a dac_sample_t each encode
// Notes: output clock is rebuilt on CLOCK; phase delay counts CLOCK cycles
// Function
// R1 - serial bits shift into mode registers only while chip select is low
// R2 - serial input is sampled on each rising serial clock edge
// R3 - readback bits shift out on SDO, valid at falling serial clock edges
// R4 - SDO is open drain: drives low only, releases for high
// R5 - parallel strap turns the four serial pins into static mode inputs
// R6 - system ties the programming strap to a fixed level
// R7 - conversion of both channels starts on rising true encode edge
// R8 - data changes at falling output clock; complement is exact inverse
// R9 - output clock phase is delayable by a mode register setting
// R10 - per-channel range flag high for out-of-range samples
// R11 - two's complement coding selectable instead of offset binary
// R12 - each channel is a 16-bit word, top bit the MSB, once per encode
module dac_top
	import dac_pkg::*;
#(
	parameter int PIPE_DEPTH = DAC_PIPE_DEPTH
) (
	// clock and control
	input  wire logic                 CLOCK,
	input  wire logic                 RESET,
	input  wire logic                 CLOCK_EN,
	// strap and encode
	input  wire logic                 PROGRAMMING_SELECT_STRAP,
	input  wire logic                 ENCODE_IN_TRUE,
	input  wire logic                 ENCODE_IN_COMPLEMENT,
	// serial port pins
	input  wire logic                 CS_N,
	input  wire logic                 SCK,
	input  wire logic                 SDI,
	input  wire logic                 SDO_IN,
	output logic                      SDO_OUT,
	output logic                      SDO_OE_N,
	// converter core
	input  dac_sample_t               CORE_SAMPLE,
	output logic                      CONVERT_START,
	// mode outputs to analog
	output logic                      DUTY_STABILIZER_ON,
	output logic [1:0]                POWER_DOWN,
	output logic [1:0]                OUTPUT_MODE,
	// output bus
	output logic [DAC_WIDTH-1:0]      CH1_SAMPLE_BUS,
	output logic [DAC_WIDTH-1:0]      CH2_SAMPLE_BUS,
	output logic                      CH1_RANGE_FLAG,
	output logic                      CH2_RANGE_FLAG,
	output logic                      DATA_OUTPUT_CLOCK_TRUE,
	output logic                      DATA_OUTPUT_CLOCK_COMPLEMENT
);

	// the pipeline needs at least one stage; very deep pipelines are not served
	// because every stage is a full sample word of flops
	if (PIPE_DEPTH < 1 || PIPE_DEPTH > 16) begin : g_depth_check
		$error("PIPE_DEPTH out of range");
	end

	function automatic logic [DAC_WIDTH-1:0] recode(input logic [DAC_WIDTH-1:0] w,
		input logic twos);
		recode = twos ? {~w[DAC_WIDTH-1], w[DAC_WIDTH-2:0]} : w;
	endfunction

	// synchronised pins: strap, encode pair, cs, sck, sdi
	logic [5:0] pin_lvl, pin_rise, pin_fall;

	dac_sync #(.WIDTH(6)) u_sync (
		.clk      (CLOCK),
		.rst      (RESET),
		.ce       (CLOCK_EN),
		.async_in ({PROGRAMMING_SELECT_STRAP, ENCODE_IN_TRUE, ENCODE_IN_COMPLEMENT,
			CS_N, SCK, SDI}),
		.level    (pin_lvl),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);

	logic sdo_meta_reg, sdo_sync_reg, sdo_meta_next, sdo_sync_next;

	logic strap_par, enc_true, enc_comp_fall, enc_true_rise;
	assign strap_par     = pin_lvl[5];
	assign enc_true      = pin_lvl[4];
	assign enc_true_rise = pin_rise[4];
	assign enc_comp_fall = pin_fall[3];

	logic [7:0] regs [DAC_REG_COUNT];
	logic       sdo_low;

	// strap only matters as a level; the system keeps it static
	dac_serial_port u_spi (
		.clk      (CLOCK),
		.rst      (RESET),
		.ce       (CLOCK_EN),
		.enable   (~strap_par), // R6
		.cs_n     (pin_lvl[2]),
		.sck_rise (pin_rise[1]),
		.sck_fall (pin_fall[1]),
		.sdi      (pin_lvl[0]),
		.regs     (regs),
		.sdo_low  (sdo_low)
	);

	dac_mode_t mode;

	always_comb begin
		mode = '0;
		if (strap_par) begin // R5
			mode.dcs_on     = pin_lvl[2];
			mode.out_mode   = pin_lvl[1] ? DAC_OUT_DDR_CMOS : DAC_OUT_FULL_CMOS;
			mode.power_down = {pin_lvl[0], sdo_sync_reg};
		end else begin
			mode.dcs_on     = regs[DAC_REG_TIMING][DAC_DCS_BIT];
			mode.clk_phase  = regs[DAC_REG_TIMING][DAC_PHASE_LSB +: DAC_PHASE_W]; // R9
			mode.out_mode   = regs[DAC_REG_OUTPUT][DAC_OUTMODE_LSB +: 2];
			mode.power_down = regs[DAC_REG_POWER][DAC_PWR_LSB +: 2];
			mode.twos_comp  = regs[DAC_REG_FORMAT][DAC_TWOS_BIT]; // R11
		end
	end

	// encode edge: the true rising edge, or a complement falling edge while the true pin is low
	logic enc_edge;
	assign enc_edge = enc_true_rise | (enc_comp_fall & ~enc_true); // R7

	// latency pipeline: each encode edge shifts one sample in and one out;
	// a stalled encode simply holds the bus, there is no timeout
	dac_sample_t          pipe_reg [PIPE_DEPTH];
	dac_sample_t          pipe_next [PIPE_DEPTH];
	logic [DAC_WIDTH-1:0] ch1_reg, ch1_next;
	logic [DAC_WIDTH-1:0] ch2_reg, ch2_next;
	logic                 of1_reg, of1_next;
	logic                 of2_reg, of2_next;
	logic                 start_reg, start_next;

	always_comb begin
		pipe_next  = pipe_reg;
		ch1_next   = ch1_reg;
		ch2_next   = ch2_reg;
		of1_next   = of1_reg;
		of2_next   = of2_reg;
		start_next = start_reg;
		if (CLOCK_EN) begin
			start_next = enc_edge;
			if (enc_edge) begin // R7
				pipe_next[0] = CORE_SAMPLE;
				for (int i = 1; i < PIPE_DEPTH; i++) begin
					pipe_next[i] = pipe_reg[i-1];
				end
				// coding is applied on the way out, so a format change needs no flush
				ch1_next = recode(pipe_reg[PIPE_DEPTH-1].ch1, mode.twos_comp); // R11 R12
				ch2_next = recode(pipe_reg[PIPE_DEPTH-1].ch2, mode.twos_comp); // R11 R12
				of1_next = pipe_reg[PIPE_DEPTH-1].ch1_range; // R10
				of2_next = pipe_reg[PIPE_DEPTH-1].ch2_range; // R10
			end
		end
	end

	// clearing the pipeline keeps the first outputs after reset at zero
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			for (int i = 0; i < PIPE_DEPTH; i++) begin
				pipe_reg[i] <= '0;
			end
			ch1_reg   <= '0;
			ch2_reg   <= '0;
			of1_reg   <= 1'b0;
			of2_reg   <= 1'b0;
			start_reg <= 1'b0;
		end else begin
			pipe_reg  <= pipe_next;
			ch1_reg   <= ch1_next;
			ch2_reg   <= ch2_next;
			of1_reg   <= of1_next;
			of2_reg   <= of2_next;
			start_reg <= start_next;
		end
	end

	// forwarded clock: a base level that inverts the encode pin, then a tap of a
	// short delay line picked by the phase setting; taps move whole edges, so the
	// clock keeps its duty cycle at every phase
	localparam int LINE_W = (1 << DAC_PHASE_W) - 2;

	logic              clk_hi_reg, clk_hi_next;
	logic [LINE_W-1:0] line_reg, line_next;
	logic [LINE_W+1:0] taps;
	logic              clk_out_reg, clk_out_next;
	logic              clk_n_reg, clk_n_next;

	always_comb begin
		clk_hi_next  = clk_hi_reg;
		line_next    = line_reg;
		taps         = '0;
		clk_out_next = clk_out_reg;
		clk_n_next   = clk_n_reg;
		if (CLOCK_EN) begin
			if (enc_edge) begin
				clk_hi_next = 1'b0; // R8
			end else if (pin_fall[4]) begin
				clk_hi_next = 1'b1;
			end
			// tap zero is the undelayed level, so at phase zero the fall meets the data;
			// line stage k holds the base level k+2 cycles old
			taps         = {line_reg, clk_hi_reg, clk_hi_next};
			line_next    = LINE_W'({line_reg, clk_hi_reg});
			clk_out_next = taps[mode.clk_phase]; // R9
			// the complement has its own flop so both pins come straight from registers
			clk_n_next   = ~taps[mode.clk_phase]; // R8
		end
	end

	// the pair resets to low and high, already inverse
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			clk_hi_reg  <= 1'b0;
			line_reg    <= '0;
			clk_out_reg <= 1'b0;
			clk_n_reg   <= 1'b1;
		end else begin
			clk_hi_reg  <= clk_hi_next;
			line_reg    <= line_next;
			clk_out_reg <= clk_out_next;
			clk_n_reg   <= clk_n_next;
		end
	end

	// serial data pin: drives low only, and its input view is synchronised for
	// the parallel power-down control
	logic sdo_out_reg, sdo_out_next;
	logic sdo_oe_reg, sdo_oe_next;

	always_comb begin
		sdo_meta_next = sdo_meta_reg;
		sdo_sync_next = sdo_sync_reg;
		sdo_out_next  = sdo_out_reg;
		sdo_oe_next   = sdo_oe_reg;
		if (CLOCK_EN) begin
			sdo_meta_next = SDO_IN;
			sdo_sync_next = sdo_meta_reg;
			// the pin only ever pulls low; the pull-up makes the ones
			sdo_out_next  = 1'b0; // R4
			sdo_oe_next   = ~(sdo_low & ~strap_par); // R4
		end
	end

	// the synchroniser resets to the pulled-up level, with the pin released
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			sdo_meta_reg <= 1'b1;
			sdo_sync_reg <= 1'b1;
			sdo_out_reg  <= 1'b0;
			sdo_oe_reg   <= 1'b1;
		end else begin
			sdo_meta_reg <= sdo_meta_next;
			sdo_sync_reg <= sdo_sync_next;
			sdo_out_reg  <= sdo_out_next;
			sdo_oe_reg   <= sdo_oe_next;
		end
	end

	// mode levels follow the strap or the registers each cycle; a low clock
	// enable holds the last levels
	logic       dcs_reg, dcs_next;
	logic [1:0] pd_reg, pd_next;
	logic [1:0] om_reg, om_next;

	always_comb begin
		dcs_next = dcs_reg;
		pd_next  = pd_reg;
		om_next  = om_reg;
		if (CLOCK_EN) begin
			dcs_next = mode.dcs_on;
			pd_next  = mode.power_down;
			om_next  = mode.out_mode;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			dcs_reg <= 1'b0;
			pd_reg  <= '0;
			om_reg  <= DAC_OUT_FULL_CMOS;
		end else begin
			dcs_reg <= dcs_next;
			pd_reg  <= pd_next;
			om_reg  <= om_next;
		end
	end

	assign CH1_SAMPLE_BUS               = ch1_reg;
	assign CH2_SAMPLE_BUS               = ch2_reg;
	assign CH1_RANGE_FLAG               = of1_reg;
	assign CH2_RANGE_FLAG               = of2_reg;
	assign DATA_OUTPUT_CLOCK_TRUE       = clk_out_reg;
	assign DATA_OUTPUT_CLOCK_COMPLEMENT = clk_n_reg;
	assign CONVERT_START                = start_reg;
	assign SDO_OUT                      = sdo_out_reg;
	assign SDO_OE_N                     = sdo_oe_reg;
	assign DUTY_STABILIZER_ON           = dcs_reg;
	assign POWER_DOWN                   = pd_reg;
	assign OUTPUT_MODE                  = om_reg;

endmodule

// File: core/dac_pkg.sv
// Purpose: shared constants and carrier types for the dual converter digital side
// Assumes: CLOCK at 100 MHz; encode and serial clock arrive asynchronously
// Notes: mode register map is a small local layout
package dac_pkg;

	localparam int DAC_WIDTH        = 16;
	localparam int DAC_REG_ADDR_W   = 3;
	localparam int DAC_REG_COUNT    = 8;
	localparam int DAC_FRAME_BITS   = 16;
	localparam int DAC_ADDR_MSB_POS = 15;
	localparam int DAC_PIPE_DEPTH   = 6;
	localparam int DAC_PHASE_W      = 2;

	// mode register indices
	localparam logic [2:0] DAC_REG_RESET  = 3'h0;
	localparam logic [2:0] DAC_REG_POWER  = 3'h1;
	localparam logic [2:0] DAC_REG_TIMING = 3'h2;
	localparam logic [2:0] DAC_REG_OUTPUT = 3'h3;
	localparam logic [2:0] DAC_REG_FORMAT = 3'h4;

	// field positions
	localparam int DAC_PWR_LSB      = 0;
	localparam int DAC_DCS_BIT      = 0;
	localparam int DAC_PHASE_LSB    = 1;
	localparam int DAC_OUTMODE_LSB  = 0;
	localparam int DAC_TWOS_BIT     = 0;
	localparam int DAC_RESET_BIT    = 7;

	// output mode codes
	localparam logic [1:0] DAC_OUT_FULL_CMOS = 2'h0;
	localparam logic [1:0] DAC_OUT_DDR_CMOS  = 2'h1;
	localparam logic [1:0] DAC_OUT_DDR_LVDS  = 2'h2;

	localparam logic [7:0] DAC_REG_RESET_VAL = 8'h00;

	typedef struct packed {
		logic [DAC_WIDTH-1:0] ch1;
		logic [DAC_WIDTH-1:0] ch2;
		logic                 ch1_range;
		logic                 ch2_range;
	} dac_sample_t;

	typedef struct packed {
		logic       dcs_on;
		logic [1:0] out_mode;
		logic [1:0] power_down;
		logic [1:0] clk_phase;
		logic       twos_comp;
	} dac_mode_t;

endpackage

// File: core/dac_sync.sv
// Purpose: two-flop synchroniser with edge outputs for asynchronous pins
// Assumes: the first stage feeds only the second
// Notes: edges derive from the second and third stages
module dac_sync
	import dac_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// clock and control
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// pins
	input  wire logic [WIDTH-1:0] async_in,
	// synchronised view
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] meta_reg, sync_reg, prev_reg;
	logic [WIDTH-1:0] meta_next, sync_next, prev_next;

	always_comb begin
		meta_next = meta_reg;
		sync_next = sync_reg;
		prev_next = prev_reg;
		if (ce) begin
			meta_next = async_in;
			sync_next = meta_reg;
			prev_next = sync_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~prev_reg;
	assign fall  = ~sync_reg & prev_reg;

endmodule

// File: core/dac_serial_port.sv
// Purpose: serial mode control port, sixteen-bit frames of r/w, address, data
// Assumes: inputs already synchronised; frame bit 15 is read flag
// Notes: readback shifts out on serial clock falling edges
module dac_serial_port
	import dac_pkg::*;
(
	// clock and control
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       enable,
	// synchronised serial pins
	input  wire logic       cs_n,
	input  wire logic       sck_rise,
	input  wire logic       sck_fall,
	input  wire logic       sdi,
	// register view
	output logic      [7:0] regs [DAC_REG_COUNT],
	output logic            sdo_low
);

	logic [DAC_FRAME_BITS-1:0] shift_reg, shift_next;
	logic [4:0]                count_reg, count_next;
	logic [7:0]                out_reg, out_next;
	logic                      rd_reg, rd_next;
	logic                      low_reg, low_next;
	logic [7:0]                regs_reg [DAC_REG_COUNT];
	logic [7:0]                regs_next [DAC_REG_COUNT];
	logic [DAC_REG_ADDR_W-1:0] addr;

	// write address: frame bits 10:8 sit one place down while the last bit is on the pin
	assign addr = shift_reg[DAC_FRAME_BITS-7:DAC_FRAME_BITS-9];

	always_comb begin
		shift_next = shift_reg;
		count_next = count_reg;
		out_next   = out_reg;
		rd_next    = rd_reg;
		low_next   = low_reg;
		regs_next  = regs_reg;
		if (ce) begin
			if (!enable || cs_n) begin
				count_next = '0;
				low_next   = 1'b0;
			end else begin
				if (sck_rise && count_reg < 5'(DAC_FRAME_BITS)) begin // R1 R2
					shift_next = {shift_reg[DAC_FRAME_BITS-2:0], sdi};
					count_next = count_reg + 5'h1;
					if (count_reg == 5'h7) begin
						rd_next  = shift_reg[6];
						out_next = regs_reg[{shift_reg[DAC_REG_ADDR_W-2:0], sdi}];
					end
					if (count_reg == 5'(DAC_FRAME_BITS - 1) && !rd_reg) begin
						regs_next[addr] = {shift_reg[6:0], sdi};
						if (addr == DAC_REG_RESET && shift_reg[6])
							regs_next = '{default: DAC_REG_RESET_VAL};
					end
				end
				if (sck_fall && rd_reg && count_reg >= 5'h8
					&& count_reg < 5'(DAC_FRAME_BITS)) begin // R3
					low_next = ~out_reg[7]; // R4
					out_next = {out_reg[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			shift_reg <= '0;
			count_reg <= '0;
			out_reg   <= '0;
			rd_reg    <= 1'b0;
			low_reg   <= 1'b0;
			regs_reg  <= '{default: DAC_REG_RESET_VAL};
		end else begin
			shift_reg <= shift_next;
			count_reg <= count_next;
			out_reg   <= out_next;
			rd_reg    <= rd_next;
			low_reg   <= low_next;
			regs_reg  <= regs_next;
		end
	end

	assign regs    = regs_reg;
	assign sdo_low = low_reg;

endmodule

// File: bench/dac_top_asserts.sv
// Purpose: port-level checks on the converter digital side
// Assumes: CLOCK_EN held high while checks run
// Notes: pins pass a two-flop synchroniser, so latencies carry slack
module dac_top_asserts
	import dac_pkg::*;
(
	// clock and reset
	input wire logic                 CLOCK,
	input wire logic                 RESET,
	// pins
	input wire logic                 PROGRAMMING_SELECT_STRAP,
	input wire logic                 ENCODE_IN_TRUE,
	input wire logic                 CS_N,
	input wire logic                 SCK,
	input wire logic                 SDO_OUT,
	input wire logic                 SDO_OE_N,
	// outputs
	input wire logic                 CONVERT_START,
	input wire logic [1:0]           OUTPUT_MODE,
	input wire logic [DAC_WIDTH-1:0] CH1_SAMPLE_BUS,
	input wire logic [DAC_WIDTH-1:0] CH2_SAMPLE_BUS,
	input wire logic                 CH1_RANGE_FLAG,
	input wire logic                 CH2_RANGE_FLAG,
	input wire logic                 DATA_OUTPUT_CLOCK_TRUE,
	input wire logic                 DATA_OUTPUT_CLOCK_COMPLEMENT
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	sequence enc_rise;
		!ENCODE_IN_TRUE ##1 ENCODE_IN_TRUE;
	endsequence
	sequence cs_idle;
		CS_N [*6];
	endsequence
	sequence strap_ddr;
		(PROGRAMMING_SELECT_STRAP && SCK) [*6];
	endsequence

	clk_inverse_a: assert property (
		DATA_OUTPUT_CLOCK_COMPLEMENT == !DATA_OUTPUT_CLOCK_TRUE)
		else $error("output clock pair not inverse");
	sdo_drain_a: assert property (SDO_OUT == 1'b0)
		else $error("serial output drove high");
	sdo_idle_a: assert property (cs_idle |-> SDO_OE_N)
		else $error("serial output pulled low while deselected");
	start_lat_a: assert property (enc_rise |-> ##[2:5] CONVERT_START)
		else $error("encode edge did not start a conversion");
	start_pulse_a: assert property (CONVERT_START |=> !CONVERT_START)
		else $error("conversion start longer than one cycle");
	bus_one_a: assert property (
		($changed(CH1_SAMPLE_BUS) || $changed(CH1_RANGE_FLAG)) |-> CONVERT_START)
		else $error("channel one changed outside an update");
	bus_two_a: assert property (
		($changed(CH2_SAMPLE_BUS) || $changed(CH2_RANGE_FLAG)) |-> CONVERT_START)
		else $error("channel two changed outside an update");
	clk_fall_a: assert property ($fell(DATA_OUTPUT_CLOCK_TRUE) |->
		(CONVERT_START || $past(CONVERT_START) || $past(CONVERT_START, 2)
		|| $past(CONVERT_START, 3)))
		else $error("output clock fell away from a data update");
	par_mode_a: assert property (strap_ddr |-> OUTPUT_MODE == DAC_OUT_DDR_CMOS)
		else $error("parallel strap ignored serial clock pin");
endmodule

bind dac_top dac_top_asserts u_chk (
	.CLOCK(CLOCK), .RESET(RESET), .PROGRAMMING_SELECT_STRAP(PROGRAMMING_SELECT_STRAP),
	.ENCODE_IN_TRUE(ENCODE_IN_TRUE), .CS_N(CS_N), .SCK(SCK), .SDO_OUT(SDO_OUT),
	.SDO_OE_N(SDO_OE_N), .CONVERT_START(CONVERT_START), .OUTPUT_MODE(OUTPUT_MODE),
	.CH1_SAMPLE_BUS(CH1_SAMPLE_BUS), .CH2_SAMPLE_BUS(CH2_SAMPLE_BUS),
	.CH1_RANGE_FLAG(CH1_RANGE_FLAG), .CH2_RANGE_FLAG(CH2_RANGE_FLAG),
	.DATA_OUTPUT_CLOCK_TRUE(DATA_OUTPUT_CLOCK_TRUE),
	.DATA_OUTPUT_CLOCK_COMPLEMENT(DATA_OUTPUT_CLOCK_COMPLEMENT));

// File: bench/dac_host_model.sv
// Purpose: serial host for the mode port with open-drain readback
// Assumes: serial clock period 80 ns, parked low between frames
// Notes: a frame shorter than 16 bits is an abort
module dac_host_model (
	// serial pins
	output logic      cs_n,
	output logic      sck,
	output logic      sdi,
	input  wire logic sdo
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		sdi  = 1'b0;
	end
	task automatic xfer(input logic rd, input logic [2:0] a, input logic [7:0] d,
		input int nb, output logic [7:0] q);
		logic [15:0] f;
		f = {rd, 4'h0, a, d};
		q = 8'h00;
		#7 cs_n = 1'b0;
		for (int i = 0; i < nb; i++) begin
			sdi = f[15 - i];
			#40 sck = 1'b1;
			#40 if (i > 7) q = {q[6:0], sdo};
			sck = 1'b0;
		end
		#40 cs_n = 1'b1;
		// released data line must not keep showing the last bit
		sdi = ~sdi;
	endtask
endmodule

// File: bench/testbench.sv
// Purpose: self-checking bench for the converter digital side
// Assumes: encode and serial clock are asynchronous to CLOCK
// Notes: a short pipeline parameter keeps the run brief
module testbench;
	import dac_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int P = 3;
	logic        clk = 1'b0, rst = 1'b1, strap = 1'b0, enc = 1'b0, diff = 1'b0;
	logic        p_cs = 1'b1, p_sck = 1'b0, p_sdi = 1'b0, p_sdo = 1'b0;
	logic        h_cs, h_sck, h_sdi, sdo_out, sdo_oe_n, sdo_w, start, dcs, f1, f2, ck, ckn;
	logic [1:0]  pd, om, dv;
	logic [15:0] b1, b2;
	logic [7:0]  d, q8;
	dac_sample_t smp = '0;
	dac_sample_t q[$];
	int          n_fail = 0, compares = 0, m0, m3;

	always #5 clk = ~clk;
	assign sdo_w = sdo_oe_n ? 1'b1 : sdo_out;

	dac_host_model u_host (.cs_n(h_cs), .sck(h_sck), .sdi(h_sdi), .sdo(sdo_w));
	dac_top #(.PIPE_DEPTH(P)) u_dut (
		.CLOCK(clk), .RESET(rst), .CLOCK_EN(1'b1),
		.PROGRAMMING_SELECT_STRAP(strap), .ENCODE_IN_TRUE(enc),
		.ENCODE_IN_COMPLEMENT(diff & ~enc),
		.CS_N(strap ? p_cs : h_cs), .SCK(strap ? p_sck : h_sck),
		.SDI(strap ? p_sdi : h_sdi), .SDO_IN(strap ? p_sdo : sdo_w),
		.SDO_OUT(sdo_out), .SDO_OE_N(sdo_oe_n), .CORE_SAMPLE(smp), .CONVERT_START(start),
		.DUTY_STABILIZER_ON(dcs), .POWER_DOWN(pd), .OUTPUT_MODE(om),
		.CH1_SAMPLE_BUS(b1), .CH2_SAMPLE_BUS(b2), .CH1_RANGE_FLAG(f1), .CH2_RANGE_FLAG(f2),
		.DATA_OUTPUT_CLOCK_TRUE(ck), .DATA_OUTPUT_CLOCK_COMPLEMENT(ckn));

	function automatic logic [15:0] coded(logic [15:0] v, bit tw);
		return {v[15] ^ tw, v[14:0]};
	endfunction
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [2:0] a, input logic [7:0] v);
		u_host.xfer(1'b0, a, v, 16, q8);
		tick(8);
	endtask
	// m returns cycles from encode fall to output clock rise
	task automatic enc_cyc(input bit tw, output int m);
		dac_sample_t e;
		smp.ch1 = 16'($urandom);
		smp.ch2 = (q.size() == 0) ? 16'h8000 : 16'($urandom);
		{smp.ch1_range, smp.ch2_range} = 2'($urandom);
		q.push_back(smp);
		enc = 1'b1;
		for (m = 0; m < 10 && start !== 1'b1; m++) tick(1);
		chk(16'(m < 10), 16'h1);
		if (q.size() > P) begin
			e = q[q.size() - 1 - P];
			chk(b1, coded(e.ch1, tw));
			chk(b2, coded(e.ch2, tw));
			chk({14'h0, f1, f2}, {14'h0, e.ch1_range, e.ch2_range});
		end
		tick(8);
		enc = 1'b0;
		for (m = 0; m < 12 && ck !== 1'b1; m++) tick(1);
		tick(12 - m);
	endtask
	task report_and_stop;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#200000;
		n_fail++;
		report_and_stop;
	end

	initial begin
		void'($urandom(49));
		tick(9);
		chk({14'h0, sdo_oe_n, ckn}, 16'h3);
		chk(b1, 16'h0);
		tick(1);
		rst = 1'b0;
		tick(3);
		d = {6'h0, 2'($urandom)};
		wr(DAC_REG_POWER, d);
		chk(16'(pd), 16'(d));
		u_host.xfer(1'b1, DAC_REG_POWER, 8'h00, 16, q8);
		tick(8);
		chk(16'(q8), 16'(d));
		u_host.xfer(1'b0, DAC_REG_POWER, ~d, 12, q8);
		tick(8);
		chk(16'(pd), 16'(d));
		for (int i = 2; i >= 0; i--) begin
			wr(DAC_REG_OUTPUT, 8'(i));
			chk(16'(om), 16'(i));
		end
		wr(DAC_REG_TIMING, 8'h01);
		chk(16'(dcs), 16'h1);
		repeat (6) enc_cyc(1'b0, m0);
		wr(DAC_REG_TIMING, 8'h07);
		repeat (2) enc_cyc(1'b0, m3);
		chk(16'(m3 - m0), 16'h3);
		wr(DAC_REG_FORMAT, 8'h01);
		q.delete();
		// differential encode: the complement fall must not add a second start
		diff = 1'b1;
		repeat (6) enc_cyc(1'b1, m3);
		wr(DAC_REG_RESET, 8'h80);
		chk({14'h0, pd}, 16'h0);
		chk(16'(dcs), 16'h0);
		// the strap only moves under reset, never while running
		rst = 1'b1;
		strap = 1'b1;
		tick(2);
		rst = 1'b0;
		for (int i = 0; i < 4; i++) begin
			{p_sdi, p_sdo} = 2'(i);
			p_sck = i[0];
			p_cs = i[0];
			tick(6);
			chk(16'(pd), 16'(i));
			chk(16'(om), i[0] ? 16'(DAC_OUT_DDR_CMOS) : 16'(DAC_OUT_FULL_CMOS));
			if (i < 2) dv[i] = dcs;
		end
		chk(16'(dv[0] ^ dv[1]), 16'h1);
		report_and_stop;
	end
endmodule
